// >>> reset_clock_sequencer.sv
// module: reset gathering, stretch sequencing, bus clock gating and status registers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module reset_clock_sequencer #(
	parameter int stab_count = reset_seq_pkg::stab_cycles,
	parameter int pin_por_count = reset_seq_pkg::pin_min_por_cycles
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// reset sources
	input wire logic power_on_pulse,
	input wire logic low_voltage_in,
	input wire logic watchdog_req,
	input wire logic bad_opcode_in,
	input wire logic bad_address_in,
	// reset pin, active low, open drain
	input wire logic reset_pin_n_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// mode inputs
	input wire logic monitor_mode,
	input wire logic pll_select,
	input wire logic wait_req,
	input wire logic break_mode,
	input wire logic break_wake,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// system outputs
	output logic internal_reset,
	output logic [15:0] reset_vector,
	output reset_seq_pkg::clk_gate_t clk_gate,
	output logic internal_bus_clocks,
	output logic flag_clear_allow,
	output logic [12:0] prescaler
);
	// ****************************************
	// synchronisers
	// ****************************************
	logic [1:0] pin_s_q;
	logic [1:0] wd_s_q;
	logic [1:0] lv_s_q;
	logic pin_low;
	logic wd_req;
	logic lv_req;

	// pin stage resets to the idle high level, so no false pin reset follows rst
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s_q <= 2'b11;
			wd_s_q <= 2'b00;
			lv_s_q <= 2'b00;
		end else begin
			pin_s_q <= {pin_s_q[0], reset_pin_n_in};
			wd_s_q <= {wd_s_q[0], watchdog_req};
			lv_s_q <= {lv_s_q[0], low_voltage_in};
		end
	end
	assign pin_low = !pin_s_q[1];
	assign wd_req = wd_s_q[1];
	assign lv_req = lv_s_q[1];

	// ****************************************
	// source gathering
	// ****************************************
	reset_seq_pkg::reset_src_t src;
	logic any_internal;
	logic long_src;

	assign src.power_on = power_on_pulse;
	assign src.low_voltage = lv_req;
	assign src.watchdog = wd_req;
	assign src.bad_opcode = bad_opcode_in;
	assign src.bad_address = bad_address_in;
	assign any_internal = |src;
	assign long_src = src.power_on || src.low_voltage;

	// ****************************************
	// sequencer
	// ****************************************
	reset_seq_pkg::seq_state_t state_q;
	reset_seq_pkg::seq_state_t state_d;
	logic [12:0] cnt_q;
	logic [12:0] cnt_d;
	logic [12:0] pin_cnt_q;
	logic [12:0] pin_cnt_d;
	logic long_q;
	logic long_d;
	logic cnt_last;
	logic pin_met;

	localparam logic [12:0] stab_last = 13'(stab_count - 1);
	localparam logic [12:0] drive_last = 13'(reset_seq_pkg::pin_drive_cycles - 1);
	localparam logic [12:0] stretch_last = 13'(reset_seq_pkg::stretch_cycles - 1);
	localparam logic [12:0] pin_short = 13'(reset_seq_pkg::pin_min_cycles);
	localparam logic [12:0] pin_long = 13'(pin_por_count);

	function automatic logic [12:0] sat_inc(input logic [12:0] v);
		sat_inc = (v == 13'h1fff) ? v : v + 13'h1;
	endfunction

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 13'h1;
		cnt_last = 1'b0;
		case (state_q)
			reset_seq_pkg::st_stab: cnt_last = (cnt_q == stab_last);
			reset_seq_pkg::st_drive: cnt_last = (cnt_q == drive_last);
			reset_seq_pkg::st_stretch: cnt_last = (cnt_q == stretch_last);
			default: cnt_last = 1'b0;
		endcase
		// a power-on or low-voltage request still standing restarts the count, so the timeout runs from its end
		if (long_src) begin
			state_d = reset_seq_pkg::st_stab;
			cnt_d = 13'h0;
		end else if (any_internal && state_q == reset_seq_pkg::st_run) begin
			state_d = reset_seq_pkg::st_drive;
			cnt_d = 13'h0;
		end else begin
			case (state_q)
				reset_seq_pkg::st_run: begin
					cnt_d = 13'h0;
					if (pin_low) begin
						state_d = reset_seq_pkg::st_pin;
					end
				end
				reset_seq_pkg::st_stab: begin
					// the 64 cycles after stabilisation are the normal 32 driven plus 32 stretched
					if (cnt_last) begin
						state_d = reset_seq_pkg::st_drive;
						cnt_d = 13'h0;
					end
				end
				reset_seq_pkg::st_drive: begin
					if (cnt_last) begin
						state_d = reset_seq_pkg::st_stretch;
						cnt_d = 13'h0;
					end
				end
				reset_seq_pkg::st_stretch: begin
					if (cnt_last) begin
						state_d = pin_low ? reset_seq_pkg::st_pin : reset_seq_pkg::st_run;
						cnt_d = 13'h0;
					end
				end
				reset_seq_pkg::st_pin: begin
					cnt_d = 13'h0;
					if (!pin_low) begin
						state_d = reset_seq_pkg::st_stretch;
					end
				end
				default: begin
					state_d = reset_seq_pkg::st_stab;
					cnt_d = 13'h0;
				end
			endcase
		end
	end

	// pin low time counted across the whole reset, so a pin held through power-on must outlast it
	assign pin_cnt_d = pin_low ? sat_inc(pin_cnt_q) : 13'h0;
	assign long_d = long_src ? 1'b1 : (state_q == reset_seq_pkg::st_run ? 1'b0 : long_q);
	assign pin_met = pin_cnt_q >= (long_q ? pin_long : pin_short);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= reset_seq_pkg::st_stab;
			cnt_q <= 13'h0;
			pin_cnt_q <= 13'h0;
			long_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pin_cnt_q <= pin_cnt_d;
			long_q <= long_d;
		end
	end

	// ****************************************
	// reset outputs and pin drive
	// ****************************************
	logic in_reset_d;
	logic pin_drive_d;

	assign in_reset_d = (state_d != reset_seq_pkg::st_run);
	assign pin_drive_d = (state_d == reset_seq_pkg::st_stab) || (state_d == reset_seq_pkg::st_drive);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			internal_reset <= 1'b1;
			reset_pin_oe <= 1'b1;
			reset_pin_out <= 1'b0;
			reset_vector <= reset_seq_pkg::vector_user;
		end else begin
			internal_reset <= in_reset_d;
			reset_pin_oe <= pin_drive_d;
			reset_pin_out <= 1'b0;
			reset_vector <= monitor_mode ? reset_seq_pkg::vector_monitor : reset_seq_pkg::vector_user;
		end
	end

	// ****************************************
	// prescaler counter
	// ****************************************
	// only internal sources clear it; an external pin reset leaves it free running
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prescaler <= 13'h0;
		end else if (any_internal) begin
			prescaler <= 13'h0;
		end else begin
			prescaler <= prescaler + 13'h1;
		end
	end

	// ****************************************
	// clock gating and bus clock
	// ****************************************
	logic gen_tick;
	logic bus_phase_q;
	logic clocks_run;

	assign clocks_run = (state_q == reset_seq_pkg::st_run) || (state_q == reset_seq_pkg::st_stretch && !long_q);

	// generator output halved gives the bus; with the generator at source/2 the bus is source/4
	bus_clk_div #(
		.div(reset_seq_pkg::gen_div)
	) u_div (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(clocks_run),
		.tick(gen_tick)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_phase_q <= 1'b0;
			internal_bus_clocks <= 1'b0;
			clk_gate.cpu_clk_en <= 1'b0;
			clk_gate.periph_clk_en <= 1'b0;
			// generator output runs during power-on so the oscillator can settle
			clk_gate.gen_out_en <= 1'b1;
		end else begin
			if (gen_tick) begin
				bus_phase_q <= !bus_phase_q;
			end
			internal_bus_clocks <= clocks_run && bus_phase_q;
			clk_gate.gen_out_en <= 1'b1;
			clk_gate.periph_clk_en <= clocks_run;
			clk_gate.cpu_clk_en <= clocks_run && !wait_req;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] cause_q;
	logic wait_break_q;
	logic clear_en_q;
	logic mode_pll_q;
	logic cause_hit;
	logic wr_break;
	logic wr_ctrl;
	logic [7:0] rd_mux;

	assign wr_break = reg_wr && (reg_addr == reset_seq_pkg::break_status_addr);
	assign wr_ctrl = reg_wr && (reg_addr == reset_seq_pkg::break_ctrl_addr);
	// no write decode for the cause register: software cannot alter it
	assign cause_hit = any_internal || (pin_met && state_q == reset_seq_pkg::st_pin);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cause_q <= reset_seq_pkg::reset_cause_rst;
			wait_break_q <= 1'b0;
			clear_en_q <= 1'b0;
			mode_pll_q <= 1'b0;
		end else begin
			if (src.power_on) begin
				cause_q <= reset_seq_pkg::reset_cause_rst;
			end else if (cause_hit) begin
				cause_q <= 8'h0;
				cause_q[reset_seq_pkg::cause_lvd_bit] <= src.low_voltage;
				cause_q[reset_seq_pkg::cause_wdog_bit] <= src.watchdog;
				cause_q[reset_seq_pkg::cause_opcode_bit] <= src.bad_opcode;
				cause_q[reset_seq_pkg::cause_addr_bit] <= src.bad_address;
				cause_q[reset_seq_pkg::cause_pin_bit] <= !any_internal;
			end
			// a break wake in the same cycle as the clearing write wins
			if (break_wake && wait_req) begin
				wait_break_q <= 1'b1;
			end else if (wr_break && !reg_wdata[reset_seq_pkg::wait_break_bit]) begin
				wait_break_q <= 1'b0;
			end
			if (wr_ctrl) begin
				clear_en_q <= reg_wdata[reset_seq_pkg::break_clear_enable_bit];
			end
			// clock source choice is only read back; both sources divide the same way
			mode_pll_q <= pll_select;
		end
	end

	assign rd_mux = (reg_addr == reset_seq_pkg::break_status_addr) ? {6'h0, wait_break_q, 1'b0} :
		(reg_addr == reset_seq_pkg::reset_cause_addr) ? cause_q :
		(reg_addr == reset_seq_pkg::break_ctrl_addr) ? {clear_en_q, 7'h0} :
		(reg_addr == reset_seq_pkg::mode_ctrl_addr) ? {7'h0, mode_pll_q} : 8'h0;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h0;
			flag_clear_allow <= 1'b1;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h0;
			flag_clear_allow <= !break_mode || clear_en_q;
		end
	end
endmodule // reset_clock_sequencer

// >>> reset_seq_pkg.sv
// package: register map, field positions, timing counts and carrier types of the reset and clock sequencer
package reset_seq_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [15:0] break_status_addr = 16'hfe00;
	localparam logic [15:0] reset_cause_addr = 16'hfe01;
	localparam logic [15:0] break_ctrl_addr = 16'hfe03;
	localparam logic [15:0] mode_ctrl_addr = 16'hfe04;
	localparam logic [7:0] reset_cause_rst = 8'h80;
	localparam int wait_break_bit = 1;
	localparam int break_clear_enable_bit = 7;
	localparam int cause_por_bit = 7;
	localparam int cause_pin_bit = 6;
	localparam int cause_wdog_bit = 5;
	localparam int cause_opcode_bit = 4;
	localparam int cause_addr_bit = 3;
	localparam int cause_lvd_bit = 1;
	// ****************************************
	// vectors
	// ****************************************
	localparam logic [15:0] vector_user = 16'hfffe;
	localparam logic [15:0] vector_monitor = 16'hfefe;
	// ****************************************
	// timing in oscillator cycles
	// ****************************************
	localparam int stab_cycles = 4096;
	localparam int pin_drive_cycles = 32;
	localparam int stretch_cycles = 32;
	localparam int pin_min_cycles = 67;
	localparam int pin_min_por_cycles = 4163;
	localparam int bus_div = 4;
	localparam int gen_div = 2;
	localparam int cnt_w = 13;

	typedef enum logic [2:0] {
		st_run = 3'b000,
		st_stab = 3'b001,
		st_drive = 3'b010,
		st_stretch = 3'b011,
		st_pin = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic power_on;
		logic low_voltage;
		logic watchdog;
		logic bad_opcode;
		logic bad_address;
	} reset_src_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic gen_out_en;
	} clk_gate_t;
endpackage

// >>> bus_clk_div.sv
// module: divides the reference clock down to the generator clock tick
`timescale 1ns/1ps
module bus_clk_div #(
	parameter int div = 2
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic run,
	// tick
	output logic tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic wrap;

	assign wrap = (cnt_q == 4'(div - 1));
	assign cnt_d = (!run || wrap) ? 4'h0 : cnt_q + 4'h1;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= run && wrap;
		end
	end
endmodule // bus_clk_div

// >>> reset_seq_sva.sv
// checker: timing relations of the reset and clock sequencer
`timescale 1ns/1ps
module reset_seq_sva #(
	parameter int stab_count = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// watched ports
	input wire logic power_on_pulse,
	input wire logic low_voltage_in,
	input wire logic bad_opcode_in,
	input wire logic monitor_mode,
	input wire logic wait_req,
	input wire logic break_mode,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic internal_reset,
	input wire logic [15:0] reset_vector,
	input wire reset_seq_pkg::clk_gate_t clk_gate,
	input wire logic flag_clear_allow,
	input wire logic [12:0] prescaler
);
	logic lv_seen;
	logic [12:0] lv_gap;
	// cycles since the low-voltage request last stood, and whether one is being served
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lv_seen <= 1'b0;
			lv_gap <= 13'h0;
		end else begin
			lv_seen <= low_voltage_in || (lv_seen && internal_reset);
			lv_gap <= low_voltage_in ? 13'h0 : ((lv_gap == 13'h1fff) ? lv_gap : lv_gap + 13'h1);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_entry;
		$rose(bad_opcode_in) && !internal_reset |=> internal_reset && reset_pin_oe;
	endproperty
	a_entry: assert property (p_entry) else $error("no reset entry");
	property p_drive;
		$rose(reset_pin_oe) && !low_voltage_in && !power_on_pulse |-> ##31 reset_pin_oe ##1 !reset_pin_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("pin drive length wrong");
	property p_stab;
		lv_seen && $fell(reset_pin_oe) |-> lv_gap == 13'(stab_count + reset_seq_pkg::pin_drive_cycles + 2);
	endproperty
	a_stab: assert property (p_stab) else $error("stabilisation length wrong");
	property p_stretch;
		$fell(reset_pin_oe) |-> ##31 internal_reset ##1 !internal_reset;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch length wrong");
	property p_pin_low;
		reset_pin_oe |-> !reset_pin_out && internal_reset;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin not low in reset");
	property p_cause_rsvd;
		$past(reg_rd) && $past(reg_addr) == reset_seq_pkg::reset_cause_addr |-> !reg_rdata[2] && !reg_rdata[0];
	endproperty
	a_cause_rsvd: assert property (p_cause_rsvd) else $error("reserved cause bits set");
	property p_vector;
		$rose(internal_reset) && $stable(monitor_mode)
			|=> reset_vector == (monitor_mode ? reset_seq_pkg::vector_monitor : reset_seq_pkg::vector_user);
	endproperty
	a_vector: assert property (p_vector) else $error("wrong reset vector");
	property p_wait;
		(wait_req && !internal_reset) [*2] |-> !clk_gate.cpu_clk_en && clk_gate.periph_clk_en;
	endproperty
	a_wait: assert property (p_wait) else $error("wait clocks wrong");
	property p_gate;
		reset_pin_oe [*2] |-> !clk_gate.cpu_clk_en && !clk_gate.periph_clk_en && clk_gate.gen_out_en;
	endproperty
	a_gate: assert property (p_gate) else $error("clocks not gated in reset");
	property p_flag;
		!break_mode [*2] |-> flag_clear_allow;
	endproperty
	a_flag: assert property (p_flag) else $error("flags blocked outside break");
	property p_presc;
		bad_opcode_in [*2] |-> prescaler == 13'h0000;
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler not cleared");
endmodule // reset_seq_sva

bind reset_clock_sequencer reset_seq_sva #(.stab_count(stab_count)) u_reset_seq_sva (.ref_clk(ref_clk), .rst(rst),
	.power_on_pulse(power_on_pulse), .low_voltage_in(low_voltage_in), .bad_opcode_in(bad_opcode_in),
	.monitor_mode(monitor_mode), .wait_req(wait_req), .break_mode(break_mode), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
	.internal_reset(internal_reset), .reset_vector(reset_vector), .clk_gate(clk_gate),
	.flag_clear_allow(flag_clear_allow), .prescaler(prescaler));

// >>> reset_line_model.sv
// partner: open-drain reset line with pull-up and a board-side pull-down
`timescale 1ns/1ps
module reset_line_model (
	// device side
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	// board side
	input wire logic board_pull_low,
	// resolved line
	output logic reset_pin_n
);
	// pull-up wins only when nobody pulls
	assign reset_pin_n = ((reset_pin_oe && !reset_pin_out) || board_pull_low) ? 1'b0 : 1'b1;
endmodule // reset_line_model

// >>> reset_clock_sequencer_tb_top.sv
// testbench: register and reset sequence scenarios for the reset and clock sequencer
`timescale 1ns/1ps
module reset_clock_sequencer_tb_top;
	localparam int cause_pos [5] = '{reset_seq_pkg::cause_addr_bit, reset_seq_pkg::cause_opcode_bit,
		reset_seq_pkg::cause_wdog_bit, reset_seq_pkg::cause_lvd_bit, reset_seq_pkg::cause_por_bit};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	// sources: address, opcode, watchdog, low voltage, power on
	logic [4:0] src_q = 5'h00;
	logic board_pull_low = 1'b0;
	logic monitor_mode = 1'b0;
	logic pll_select = 1'b0;
	logic wait_req = 1'b0;
	logic break_mode = 1'b0;
	logic break_wake = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reset_pin_n, reset_pin_out, reset_pin_oe, internal_reset, internal_bus_clocks, flag_clear_allow;
	logic [7:0] reg_rdata;
	logic [15:0] reset_vector;
	logic [12:0] prescaler;
	reset_seq_pkg::clk_gate_t clk_gate;
	int mismatches = 0;
	int checks_done = 0;
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	reset_line_model u_reset_line_model (.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.board_pull_low(board_pull_low), .reset_pin_n(reset_pin_n));
	// short counts keep the run brief
	reset_clock_sequencer #(.stab_count(16), .pin_por_count(83)) u_reset_clock_sequencer (.ref_clk(ref_clk),
		.rst(rst), .power_on_pulse(src_q[4]), .low_voltage_in(src_q[3]), .watchdog_req(src_q[2]),
		.bad_opcode_in(src_q[1]), .bad_address_in(src_q[0]), .reset_pin_n_in(reset_pin_n),
		.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .monitor_mode(monitor_mode),
		.pll_select(pll_select), .wait_req(wait_req), .break_mode(break_mode), .break_wake(break_wake),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.internal_reset(internal_reset), .reset_vector(reset_vector), .clk_gate(clk_gate),
		.internal_bus_clocks(internal_bus_clocks), .flag_clear_allow(flag_clear_allow), .prescaler(prescaler));
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(16'(reg_rdata), 16'(exp));
	endtask
	task automatic wait_ir(input logic lvl);
		int n;
		n = 0;
		while (internal_reset !== lvl && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 400) begin
			mismatches++;
			test_done();
		end
	endtask
	// source held until seen, since some are synchronised first
	task automatic fire(input int i);
		@(posedge ref_clk);
		src_q[i] <= 1'b1;
		wait_ir(1'b1);
		@(posedge ref_clk);
		src_q[i] <= 1'b0;
		wait_ir(1'b0);
	endtask
	initial begin
		int n;
		logic prev;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		wait_ir(1'b0);
		rd(reset_seq_pkg::reset_cause_addr, reset_seq_pkg::reset_cause_rst);
		rd(reset_seq_pkg::break_status_addr, 8'h00);
		rd(reset_seq_pkg::break_ctrl_addr, 8'h00);
		rd(16'hfe02, 8'h00);
		$display("test register defaults done");
		for (int i = 0; i < 5; i++) begin
			fire(i);
			rd(reset_seq_pkg::reset_cause_addr, 8'h01 << cause_pos[i]);
			chk(reset_vector, reset_seq_pkg::vector_user);
		end
		@(posedge ref_clk);
		monitor_mode <= 1'b1;
		fire(1);
		chk(reset_vector, reset_seq_pkg::vector_monitor);
		@(posedge ref_clk);
		monitor_mode <= 1'b0;
		board_pull_low <= 1'b1;
		repeat (40) @(posedge ref_clk);
		#1;
		n = int'(prescaler);
		repeat (50) @(posedge ref_clk);
		board_pull_low <= 1'b0;
		#1;
		chk(16'(internal_reset), 16'h0001);
		chk(16'(prescaler), 16'(13'(n + 50)));
		wait_ir(1'b0);
		rd(reset_seq_pkg::reset_cause_addr, 8'h40);
		$display("test reset sources done");
		wr(reset_seq_pkg::break_ctrl_addr, 8'h80);
		rd(reset_seq_pkg::break_ctrl_addr, 8'h80);
		@(posedge ref_clk);
		break_mode <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(16'(flag_clear_allow), 16'h0001);
		wr(reset_seq_pkg::break_ctrl_addr, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(16'(flag_clear_allow), 16'h0000);
		@(posedge ref_clk);
		break_mode <= 1'b0;
		wait_req <= 1'b1;
		break_wake <= 1'b1;
		@(posedge ref_clk);
		wait_req <= 1'b0;
		break_wake <= 1'b0;
		rd(reset_seq_pkg::break_status_addr, 8'h02);
		wr(reset_seq_pkg::break_status_addr, 8'h00);
		rd(reset_seq_pkg::break_status_addr, 8'h00);
		wr(reset_seq_pkg::reset_cause_addr, 8'h00);
		rd(reset_seq_pkg::reset_cause_addr, 8'h40);
		$display("test break registers done");
		n = 0;
		prev = internal_bus_clocks;
		repeat (32) begin
			@(posedge ref_clk);
			#1;
			n += (internal_bus_clocks !== prev) ? 1 : 0;
			prev = internal_bus_clocks;
		end
		chk(16'(n), 16'h0010);
		@(posedge ref_clk);
		wait_req <= 1'b1;
		pll_select <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(clk_gate[2:1]), 16'h0001);
		rd(reset_seq_pkg::mode_ctrl_addr, 8'h01);
		$display("test clocks done");
		test_done();
	end
endmodule // reset_clock_sequencer_tb_top
